/* hdl/drl_pkg.sv */
// Purpose: Shared constants and types for the DC link / current ramp limiter
// Assumes: 10 MHz system clock, APB register access, 32-bit data
// Notes: Voltages in 0.1 V, currents in 0.1 A, speeds in 0.01 Hz, gain in 0.01 units
package drl_pkg;
    localparam int unsigned CLK_HZ = 10000000;
    localparam int unsigned TICK_US = 1000;
    localparam int unsigned TICK_CYCLES = (CLK_HZ / 1000000) * TICK_US;

    localparam logic [11:0] OFS_KIND = 12'h000;
    localparam logic [11:0] OFS_THRESHOLD = 12'h004;
    localparam logic [11:0] OFS_GAIN = 12'h008;
    localparam logic [11:0] OFS_MAX_CURRENT = 12'h00c;
    localparam logic [11:0] OFS_RAMP3_TIME = 12'h010;
    localparam logic [11:0] OFS_MIN_SPEED = 12'h014;
    localparam logic [11:0] OFS_MAX_SPEED = 12'h018;
    localparam logic [11:0] OFS_LINE_SEL = 12'h01c;
    localparam logic [11:0] OFS_STATUS = 12'h020;
    localparam logic [11:0] OFS_SPEED_OUT = 12'h024;

    localparam logic [1:0] KIND_RST = 2'h0;
    localparam logic [15:0] THR_MIN = 16'h0d3e;
    localparam logic [15:0] THR_MAX = 16'h2ee0;
    localparam logic [15:0] THR_LINE0 = 16'h0fa0;
    localparam logic [15:0] THR_LINE1 = 16'h1f40;
    localparam logic [15:0] THR_LINE2 = 16'h2710;
    localparam logic [15:0] GAIN_MAX = 16'h03e7;
    localparam logic [15:0] GAIN_RST = 16'h0096;
    localparam logic [15:0] CUR_MAX = 16'h07d0;
    localparam logic [15:0] CUR_RST = 16'h0096;
    localparam logic [15:0] RAMP_MIN = 16'h0001;
    localparam logic [15:0] RAMP_MAX = 16'h2706;
    localparam logic [15:0] RAMP_RST = 16'h0032;
    localparam logic [15:0] MIN_SPD_RST = 16'h0000;
    localparam logic [15:0] MAX_SPD_RST = 16'h1770;
    localparam logic [1:0] LINE_RST = 2'h0;
    localparam logic [1:0] LINE_MAX = 2'h2;

    localparam int unsigned ST_VOLT = 0;
    localparam int unsigned ST_CURR = 1;
    localparam int unsigned ST_FREEZE = 2;
    localparam int unsigned ST_FORCE = 3;

    typedef enum logic [1:0] {
        DRL_IDLE = 2'b00,
        DRL_VOLT = 2'b01,
        DRL_CURR = 2'b10
    } drl_act_t;

    typedef struct packed {
        logic [1:0] kind;
        logic [15:0] threshold;
        logic [15:0] gain;
        logic [15:0] max_current;
        logic [15:0] ramp3_time;
        logic [15:0] min_speed;
        logic [15:0] max_speed;
    } drl_cfg_t;

    typedef struct packed {
        logic [15:0] dc_volt;
        logic [15:0] current;
        logic [15:0] ramp_speed;
        logic accel;
        logic decel;
    } drl_meas_t;
endpackage

/* hdl/drl_step.sv */
// Purpose: Third-ramp step generator, one speed step per tick toward a target
// Assumes: Tick is a one-cycle enable; ramp time in 0.1 s, speeds in 0.01 Hz
// Notes: Step = max_speed / (ramp time in ticks); at least one count per tick
`timescale 1ns/1ns
`default_nettype none
module drl_step (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [15:0] max_speed,
    input wire logic [15:0] ramp3_time,
    output logic [15:0] step
);
    // Ticks of 1 ms; 0.1 s is 100 ticks
    localparam logic [31:0] TICKS_PER_UNIT = 32'h00000064;
    logic [15:0] step_r;
    logic [15:0] step_nxt;
    logic [31:0] quot;

    always_comb begin
        quot = {16'h0000, max_speed} / (ramp3_time * TICKS_PER_UNIT);
        step_nxt = (quot[15:0] == 16'h0000) ? 16'h0001 : quot[15:0];
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            step_r <= 16'h0001;
        end else begin
            step_r <= step_nxt;
        end
    end

    assign step = step_r;
endmodule
`default_nettype wire

/* hdl/drl_limiter.sv */
// Purpose: DC link voltage and output current limiter acting on the speed ramp
// Assumes: APB slave; measurements valid each cycle from logic on clk_sys
// Notes: Output speed command in 0.01 Hz; overrides the ramp while limiting
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module drl_limiter #(
    parameter int unsigned TICK_DIV = drl_pkg::TICK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire drl_pkg::drl_meas_t meas,
    output logic [15:0] speed_cmd,
    output logic ramp_freeze,
    output logic voltage_limit_active,
    output logic current_limit_active
);
    // Tick counter is 16 bits and needs at least two states
    if (TICK_DIV < 2 || TICK_DIV > 65535) begin : g_bad_tick
        $error("TICK_DIV out of range");
    end

    function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                            input logic [15:0] hi);
        clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    function automatic logic [15:0] line_default(input logic [1:0] sel);
        unique case (sel)
            2'h0: line_default = drl_pkg::THR_LINE0;
            2'h1: line_default = drl_pkg::THR_LINE1;
            default: line_default = drl_pkg::THR_LINE2;
        endcase
    endfunction

    // Register state
    drl_pkg::drl_cfg_t cfg_r, cfg_nxt;
    logic [1:0] line_r, line_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;

    // Limiter state
    drl_pkg::drl_act_t act_r, act_nxt;
    logic [15:0] spd_r, spd_nxt;
    logic freeze_r, freeze_nxt;
    logic vact_r, vact_nxt;
    logic cact_r, cact_nxt;
    logic [15:0] tick_cnt_r, tick_cnt_nxt;
    logic tick_r, tick_nxt;

    logic [15:0] step;
    logic [15:0] status_w;
    logic wr_en;
    logic rd_en;

    drl_step u_step (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .max_speed(cfg_r.max_speed),
        .ramp3_time(cfg_r.ramp3_time),
        .step(step)
    );

    assign wr_en = psel && penable && pwrite && !pready_r;
    assign rd_en = psel && penable && !pwrite && !pready_r;
    assign status_w = {12'h000, freeze_r, act_r == drl_pkg::DRL_CURR && !freeze_r, cact_r,
                       vact_r};

    // APB slave: one wait state, answer in the second access cycle
    always_comb begin
        cfg_nxt = cfg_r;
        line_nxt = line_r;
        prdata_nxt = prdata_r;
        pready_nxt = 1'b0;
        pslverr_nxt = 1'b0;
        if (wr_en) begin
            pready_nxt = 1'b1;
            unique case (paddr)
                drl_pkg::OFS_KIND: cfg_nxt.kind = pwdata[1:0];
                drl_pkg::OFS_THRESHOLD: cfg_nxt.threshold =
                    clamp16(pwdata[15:0], drl_pkg::THR_MIN, drl_pkg::THR_MAX);
                drl_pkg::OFS_GAIN: cfg_nxt.gain =
                    clamp16(pwdata[15:0], 16'h0000, drl_pkg::GAIN_MAX);
                drl_pkg::OFS_MAX_CURRENT: cfg_nxt.max_current =
                    clamp16(pwdata[15:0], 16'h0000, drl_pkg::CUR_MAX);
                drl_pkg::OFS_RAMP3_TIME: cfg_nxt.ramp3_time =
                    clamp16(pwdata[15:0], drl_pkg::RAMP_MIN, drl_pkg::RAMP_MAX);
                drl_pkg::OFS_MIN_SPEED: cfg_nxt.min_speed = pwdata[15:0];
                drl_pkg::OFS_MAX_SPEED: cfg_nxt.max_speed = pwdata[15:0];
                drl_pkg::OFS_LINE_SEL: begin
                    // Changing the line selection reloads the threshold default
                    line_nxt = (pwdata[1:0] > drl_pkg::LINE_MAX) ? drl_pkg::LINE_MAX
                                                                 : pwdata[1:0];
                    cfg_nxt.threshold = line_default(line_nxt);
                end
                drl_pkg::OFS_STATUS, drl_pkg::OFS_SPEED_OUT: pslverr_nxt = 1'b1;
                default: pslverr_nxt = 1'b1;
            endcase
        end else if (rd_en) begin
            pready_nxt = 1'b1;
            prdata_nxt = 32'h00000000;
            unique case (paddr)
                drl_pkg::OFS_KIND: prdata_nxt[1:0] = cfg_r.kind;
                drl_pkg::OFS_THRESHOLD: prdata_nxt[15:0] = cfg_r.threshold;
                drl_pkg::OFS_GAIN: prdata_nxt[15:0] = cfg_r.gain;
                drl_pkg::OFS_MAX_CURRENT: prdata_nxt[15:0] = cfg_r.max_current;
                drl_pkg::OFS_RAMP3_TIME: prdata_nxt[15:0] = cfg_r.ramp3_time;
                drl_pkg::OFS_MIN_SPEED: prdata_nxt[15:0] = cfg_r.min_speed;
                drl_pkg::OFS_MAX_SPEED: prdata_nxt[15:0] = cfg_r.max_speed;
                drl_pkg::OFS_LINE_SEL: prdata_nxt[1:0] = line_r;
                drl_pkg::OFS_STATUS: prdata_nxt[15:0] = status_w;
                drl_pkg::OFS_SPEED_OUT: prdata_nxt[15:0] = spd_r;
                default: pslverr_nxt = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cfg_r.kind <= drl_pkg::KIND_RST;
            cfg_r.threshold <= drl_pkg::THR_LINE0;
            cfg_r.gain <= drl_pkg::GAIN_RST;
            cfg_r.max_current <= drl_pkg::CUR_RST;
            cfg_r.ramp3_time <= drl_pkg::RAMP_RST;
            cfg_r.min_speed <= drl_pkg::MIN_SPD_RST;
            cfg_r.max_speed <= drl_pkg::MAX_SPD_RST;
            line_r <= drl_pkg::LINE_RST;
            prdata_r <= 32'h00000000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            cfg_r <= cfg_nxt;
            line_r <= line_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // Limiter decision and speed command
    logic volt_hold_kind;
    logic cur_hold_kind;
    logic volt_over;
    logic cur_over;
    logic volt_req;
    logic [16:0] verr;
    logic [31:0] corr;
    logic [32:0] sum;
    logic [16:0] up;
    logic [16:0] dn;

    always_comb begin
        tick_cnt_nxt = tick_cnt_r + 16'h0001;
        tick_nxt = 1'b0;
        if (tick_cnt_r >= 16'(TICK_DIV - 1)) begin
            tick_cnt_nxt = 16'h0000;
            tick_nxt = 1'b1;
        end

        // Kinds 0 and 2 hold on voltage, kinds 2 and 3 hold on current
        volt_hold_kind = !cfg_r.kind[0];
        cur_hold_kind = cfg_r.kind[1];
        volt_over = meas.dc_volt >= cfg_r.threshold;
        cur_over = meas.current > cfg_r.max_current;
        // Freeze on voltage only matters while braking
        volt_req = volt_over && (!volt_hold_kind || meas.decel);
        verr = {1'b0, meas.dc_volt} - {1'b0, cfg_r.threshold};
        corr = 32'(verr[15:0]) * 32'(cfg_r.gain);
        up = {1'b0, spd_r} + {1'b0, step};
        dn = {1'b0, spd_r} - {1'b0, step};
        // Wide enough for a full-scale error times full gain, so the clamp never sees a wrap
        sum = 33'h000000000;

        act_nxt = drl_pkg::DRL_IDLE;
        freeze_nxt = 1'b0;
        spd_nxt = spd_r;
        vact_nxt = volt_req;
        cact_nxt = cur_over && !volt_req;

        if (volt_req) begin
            act_nxt = drl_pkg::DRL_VOLT;
            if (volt_hold_kind) begin
                freeze_nxt = 1'b1;
            end else begin
                // Gain in 0.01 and error in 0.1 V give 0.001 Hz; scale to 0.01 Hz
                sum = 33'(meas.ramp_speed) + 33'(corr / 32'h0000000a);
                spd_nxt = (sum > 33'(cfg_r.max_speed)) ? cfg_r.max_speed : sum[15:0];
            end
        end else if (cur_over) begin
            act_nxt = drl_pkg::DRL_CURR;
            if (cur_hold_kind) begin
                freeze_nxt = 1'b1;
            end else if (tick_r) begin
                // Zero ramp input: walk down on the third ramp toward minimum
                spd_nxt = (dn[16] || dn[15:0] < cfg_r.min_speed) ? cfg_r.min_speed
                                                                 : dn[15:0];
            end
        end else begin
            act_nxt = drl_pkg::DRL_IDLE;
            spd_nxt = meas.ramp_speed;
        end

        // Returning from a forced slowdown climbs back on the third ramp
        if (act_r == drl_pkg::DRL_CURR && act_nxt == drl_pkg::DRL_IDLE && !cur_hold_kind) begin
            spd_nxt = spd_r;
            if (tick_r) begin
                spd_nxt = (up > {1'b0, meas.ramp_speed}) ? meas.ramp_speed : up[15:0];
            end
            if (spd_nxt != meas.ramp_speed) begin
                act_nxt = drl_pkg::DRL_CURR;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            act_r <= drl_pkg::DRL_IDLE;
            spd_r <= 16'h0000;
            freeze_r <= 1'b0;
            vact_r <= 1'b0;
            cact_r <= 1'b0;
            tick_cnt_r <= 16'h0000;
            tick_r <= 1'b0;
        end else begin
            act_r <= act_nxt;
            spd_r <= spd_nxt;
            freeze_r <= freeze_nxt;
            vact_r <= vact_nxt;
            cact_r <= cact_nxt;
            tick_cnt_r <= tick_cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign speed_cmd = spd_r;
    assign ramp_freeze = freeze_r;
    assign voltage_limit_active = vact_r;
    assign current_limit_active = cact_r;
endmodule
`default_nettype wire

/* verif/drl_limiter_props.sv */
// Purpose: Port-level checks on the limiter
// Assumes: One clk_sys domain, sys_rst synchronous
// Notes: Limits are not visible at the ports, so checks avoid thresholds
`timescale 1ns/1ns
`default_nettype none
module drl_limiter_props (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [15:0] speed_cmd,
    input wire logic ramp_freeze,
    input wire logic voltage_limit_active,
    input wire logic current_limit_active
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    chk_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("no answer after access");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("answer longer than one cycle");
    chk_ready_inside: assert property (pready |-> psel && penable)
        else $error("answer outside access");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("error without answer");
    chk_read_upper: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0)
        else $error("upper read bits set");
    chk_volt_first: assert property (voltage_limit_active |-> !current_limit_active)
        else $error("current action beside voltage action");
    chk_freeze_cause: assert property (ramp_freeze |-> voltage_limit_active
        || current_limit_active)
        else $error("freeze without limiting");
    chk_freeze_hold: assert property (ramp_freeze [*3] |-> $stable(speed_cmd))
        else $error("speed moved while frozen");
    cov_volt: cover property ($rose(voltage_limit_active));
    cov_curr: cover property ($rose(current_limit_active));
    cov_err: cover property (pslverr);
endmodule
bind drl_limiter drl_limiter_props u_props (.clk_sys, .sys_rst, .psel, .penable, .pwrite,
    .prdata, .pready, .pslverr, .speed_cmd, .ramp_freeze, .voltage_limit_active,
    .current_limit_active);
`default_nettype wire

/* verif/drl_ramp_model.sv */
// Purpose: Speed ramp generator beside the limiter
// Assumes: Step of 10 counts per cycle, references on that grid
// Notes: Freeze holds the ramp but keeps direction flags up
`timescale 1ns/1ns
`default_nettype none
module drl_ramp_model (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [15:0] ref_speed,
    input wire logic [15:0] dc_volt,
    input wire logic [15:0] current,
    input wire logic ramp_freeze,
    output var drl_pkg::drl_meas_t meas
);
    logic [15:0] spd_r;
    logic [15:0] spd_nxt;
    // No rheostatic braking here, so voltage limiting stays enabled
    always_comb begin
        spd_nxt = spd_r;
        if (!ramp_freeze && spd_r < ref_speed) begin
            spd_nxt = spd_r + 16'h000a;
        end else if (!ramp_freeze && spd_r > ref_speed) begin
            spd_nxt = spd_r - 16'h000a;
        end
        meas = '{dc_volt, current, spd_r, spd_r < ref_speed, spd_r > ref_speed};
    end
    always_ff @(posedge clk_sys) begin
        spd_r <= sys_rst ? 16'h0 : spd_nxt;
    end
endmodule
`default_nettype wire

/* verif/test_drl_limiter.sv */
// Purpose: Self-checking bench for the limiter
// Assumes: TICK_DIV of 10, ramp model steps 10 per cycle
// Notes: Outputs are read at the edge, before that edge's updates
`timescale 1ns/1ns
`default_nettype none
module test_drl_limiter;
    logic clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr, e;
    logic ramp_freeze, voltage_limit_active, current_limit_active;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [15:0] speed_cmd, ref_speed, dc_volt, current, s0;
    drl_pkg::drl_meas_t meas;
    int error_cnt = 0;
    int compares = 0;
    drl_limiter #(.TICK_DIV(10)) u_dut (.clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .meas, .speed_cmd, .ramp_freeze,
        .voltage_limit_active, .current_limit_active);
    drl_ramp_model u_ramp (.clk_sys, .sys_rst, .ref_speed, .dc_volt, .current, .ramp_freeze,
        .meas);
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic give_verdict;
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        compares++;
        if (g !== x) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            error_cnt++;
            give_verdict();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(q, x);
    endtask
    task automatic wrd(input logic [11:0] a, input logic [31:0] d, input logic [11:0] r,
        input logic [31:0] x);
        apb(1'b1, a, d);
        rd(r, x);
    endtask
    initial begin
        cyc(20000);
        error_cnt++;
        give_verdict();
    end
    initial begin
        {sys_rst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 12'h0, 32'h0};
        {ref_speed, dc_volt, current} = {16'h0, 16'h0bb8, 16'h0064};
        cyc(12);
        chk({speed_cmd, ramp_freeze, pready}, 32'h0);
        sys_rst <= 1'b0;
        rd(drl_pkg::OFS_KIND, 32'h0);
        rd(drl_pkg::OFS_THRESHOLD, 32'h0fa0);
        rd(drl_pkg::OFS_GAIN, 32'h0096);
        rd(drl_pkg::OFS_RAMP3_TIME, 32'h0032);
        rd(12'h040, 32'h0);
        chk(e, 32'h1);
        apb(1'b1, drl_pkg::OFS_SPEED_OUT, 32'h5);
        chk(e, 32'h1);
        rd(drl_pkg::OFS_GAIN, 32'h0096);
        chk(e, 32'h0);
        wrd(drl_pkg::OFS_MIN_SPEED, 32'h0, drl_pkg::OFS_MAX_SPEED, 32'h1770);
        wrd(drl_pkg::OFS_GAIN, 32'h5dc, drl_pkg::OFS_GAIN, 32'h03e7);
        wrd(drl_pkg::OFS_THRESHOLD, 32'h64, drl_pkg::OFS_THRESHOLD, 32'h0d3e);
        wrd(drl_pkg::OFS_LINE_SEL, 32'h1, drl_pkg::OFS_THRESHOLD, 32'h1f40);
        wrd(drl_pkg::OFS_LINE_SEL, 32'h2, drl_pkg::OFS_THRESHOLD, 32'h2710);
        wrd(drl_pkg::OFS_MAX_CURRENT, 32'h7d1, drl_pkg::OFS_MAX_CURRENT, 32'h07d0);
        wrd(drl_pkg::OFS_RAMP3_TIME, 32'h0, drl_pkg::OFS_RAMP3_TIME, 32'h0001);
        wrd(drl_pkg::OFS_LINE_SEL, 32'h0, drl_pkg::OFS_THRESHOLD, 32'h0fa0);
        rd(drl_pkg::OFS_LINE_SEL, 32'h0);
        wrd(drl_pkg::OFS_MAX_CURRENT, 32'h96, drl_pkg::OFS_GAIN, 32'h03e7);
        apb(1'b1, drl_pkg::OFS_GAIN, 32'h96);
        $display("test registers done");
        ref_speed <= 16'h07d0;
        cyc(250);
        dc_volt <= 16'h1004;
        cyc(5);
        chk({voltage_limit_active, ramp_freeze, speed_cmd}, 32'h07d0);
        ref_speed <= 16'h03e8;
        current <= 16'h00c8;
        cyc(5);
        chk({voltage_limit_active, current_limit_active, ramp_freeze}, 32'h5);
        s0 = speed_cmd;
        cyc(10);
        chk(speed_cmd, s0);
        rd(drl_pkg::OFS_STATUS, 32'h9);
        rd(drl_pkg::OFS_SPEED_OUT, 32'(s0));
        {dc_volt, current, ref_speed} <= {16'h0bb8, 16'h0064, 16'h07d0};
        cyc(60);
        $display("test voltage hold done");
        for (int k = 1; k < 4; k += 2) begin
            apb(1'b1, drl_pkg::OFS_KIND, 32'(k));
            dc_volt <= 16'h1004;
            cyc(5);
            chk(speed_cmd, 32'h0dac);
            ref_speed <= 16'h0bb8;
            cyc(5);
            chk(voltage_limit_active, 32'h1);
            {dc_volt, ref_speed} <= {16'h0bb8, 16'h07d0};
            cyc(150);
        end
        $display("test voltage speedup done");
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, drl_pkg::OFS_KIND, 32'(k));
            current <= 16'h00c8;
            cyc(5);
            s0 = speed_cmd;
            cyc(10);
            chk(speed_cmd, s0 - 16'h003c);
            cyc(400);
            chk({current_limit_active, speed_cmd}, 32'h10000);
            rd(drl_pkg::OFS_STATUS, 32'h6);
            current <= 16'h0064;
            cyc(500);
            chk(speed_cmd, 32'h07d0);
        end
        $display("test current slowdown done");
        for (int k = 2; k < 4; k++) begin
            apb(1'b1, drl_pkg::OFS_KIND, 32'(k));
            {ref_speed, current} <= {16'h0fa0, 16'h00c8};
            cyc(5);
            s0 = speed_cmd;
            cyc(10);
            chk({ramp_freeze, current_limit_active, speed_cmd}, {2'b11, s0});
            ref_speed <= 16'h03e8;
            cyc(10);
            chk({ramp_freeze, speed_cmd}, {1'b1, s0});
            current <= 16'h0064;
            cyc(5);
            chk(ramp_freeze, 32'h0);
            ref_speed <= 16'h07d0;
            cyc(250);
        end
        $display("test current freeze done");
        give_verdict();
    end
endmodule
`default_nettype wire
